// ---- rtc_startup_map.svh ----
// register map and field positions of the rtc start-up and interrupt enable block
// assumes apb byte addresses, one 8-bit register per aligned 32-bit word
`ifndef RTC_STARTUP_MAP_SVH
`define RTC_STARTUP_MAP_SVH
// ----------------------------------------------------------------------
// register indices; each register sits at four times its index
// ----------------------------------------------------------------------
`define REALTIME_MODE_OFFSET    8'h01
`define PERIODIC_FLAG_OFFSET    8'h03
`define INTR_ENABLE_1_OFFSET    8'h04
`define STATUS_OFFSET           8'h08
`define TEST_MODE_OFFSET        8'h1F
// ----------------------------------------------------------------------
// apb byte addresses
// ----------------------------------------------------------------------
`define REALTIME_MODE_ADDR      8'h04
`define PERIODIC_FLAG_ADDR      8'h0C
`define INTR_ENABLE_1_ADDR      8'h10
`define STATUS_ADDR             8'h20
`define TEST_MODE_ADDR          8'h7C
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TEST_ENTRY_BIT          7
`define OSC_FAIL_BIT            6
`define CLOCK_START_BIT         3
`define XTAL_SEL_HI             7
`define XTAL_SEL_LO             6
`define POWER_FAIL_EN_BIT       7
`define OSC_FAIL_DISABLE_BIT    0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define REG_RESET_VALUE         8'h00
`endif

// ---- rtc_startup_pkg.sv ----
// types shared by the rtc start-up block
// assumes the map header is included where offsets are needed
package rtc_startup_pkg;
    // crystal frequency selection, codes as held in the mode register
    typedef enum logic [1:0] {
        XTAL_32768_HZ   = 2'b00,
        XTAL_4194304_HZ = 2'b01,
        XTAL_4915200_HZ = 2'b10,
        XTAL_32000_HZ   = 2'b11
    } xtal_type;
    // supply operating mode
    typedef enum logic {
        MODE_SINGLE_SUPPLY  = 1'b0,
        MODE_BATTERY_BACKED = 1'b1
    } supply_type;
endpackage

// ---- rtc_startup.sv ----
// apb register slave for the rtc start-up, supply mode and interrupt enable bits
// assumes a single 25 MHz clock, synchronous inputs and an apb master; the analog
// oscillator reports its state on OSC_RUNNING
`timescale 1ns/1ps
`include "rtc_startup_map.svh"

module rtc_startup
    import rtc_startup_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        OSC_RUNNING,
    output logic             TEST_MODE,
    output logic             OSC_FAIL_DISABLE,
    output logic             CLOCK_RUN,
    output logic      [1:0]  XTAL_SELECT,
    output logic             BATTERY_BACKED,
    output logic             POWER_LOSS_INPUT_EN,
    output logic      [7:0]  INTR_ENABLE
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic       test_mode;
    logic [7:0] test_reg;
    logic [7:0] mode_reg;
    logic [7:0] intr_enable_1;
    supply_type supply_mode;
    xtal_type   xtal_code;
    logic [31:0] rdata;
    logic        slverr;

    // ------------------------------------------------------------------
    // address mapping
    // ------------------------------------------------------------------
    // each register owns one aligned word at four times its index; index
    // bits above 5 cannot reach an 8-bit byte address and are dropped
    function automatic logic [7:0] reg_addr(input logic [7:0] index);
        return {index[5:0], 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // zero wait states: the access phase completes in its first cycle
    wire access    = PSEL & PENABLE;
    wire wr        = access & PWRITE;
    wire hit_flag  = (PADDR == reg_addr(`PERIODIC_FLAG_OFFSET));
    wire hit_mode  = (PADDR == reg_addr(`REALTIME_MODE_OFFSET));
    wire hit_ie1   = (PADDR == reg_addr(`INTR_ENABLE_1_OFFSET));
    wire hit_test  = (PADDR == reg_addr(`TEST_MODE_OFFSET));
    wire hit_stat  = (PADDR == reg_addr(`STATUS_OFFSET));
    wire mapped    = hit_flag | hit_mode | hit_ie1 | hit_test | hit_stat;
    wire [7:0] wbyte = PWDATA[7:0];
    // oscillator fail disable lets test keep the flag clear with no crystal
    wire osc_fail  = ~OSC_RUNNING & ~test_reg[`OSC_FAIL_DISABLE_BIT];

    wire start_ok  = wbyte[`CLOCK_START_BIT] & ~osc_fail;
    wire [7:0] next_mode = {wbyte[7:4], start_ok, wbyte[2:0]};

    wire [7:0] flag_view = {test_mode, osc_fail, 6'h00};
    wire [7:0] stat_view = {6'h00, supply_mode, osc_fail};

    assign PREADY  = 1'b1;
    assign PRDATA  = rdata;
    assign PSLVERR = slverr;

    // read data mux, zero for unmapped addresses
    wire [7:0] read_byte = hit_flag ? flag_view :
                           hit_mode ? mode_reg :
                           hit_ie1  ? intr_enable_1 :
                           hit_test ? test_reg :
                           hit_stat ? stat_view : 8'h00;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // test mode entry and exit
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            test_mode <= 1'b0;
        end else if (wr && hit_flag) begin
            test_mode <= wbyte[`TEST_ENTRY_BIT];
        end
    end

    // zero write clears test conditions; only writable in test mode
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            test_reg <= `REG_RESET_VALUE;
        end else if (wr && hit_test && test_mode) begin
            test_reg <= wbyte;
        end
    end

    // crystal select and clock start stored here
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg <= `REG_RESET_VALUE;
        end else if (wr && hit_mode) begin
            mode_reg <= next_mode;
        end else if (osc_fail) begin
            mode_reg[`CLOCK_START_BIT] <= 1'b0; // a failing oscillator stops the clock
        end
    end

    // battery backed entered only with oscillator good, then kept if it fails
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            supply_mode <= MODE_SINGLE_SUPPLY;
        end else if (wr && hit_flag) begin
            if (wbyte[`OSC_FAIL_BIT]) begin
                supply_mode <= MODE_SINGLE_SUPPLY;
            end else if (!osc_fail) begin
                supply_mode <= MODE_BATTERY_BACKED;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            intr_enable_1 <= `REG_RESET_VALUE;
        end else if (wr && hit_ie1) begin
            intr_enable_1 <= wbyte;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata  <= 32'h0000_0000;
            slverr <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            rdata  <= {24'h000000, read_byte};
            slverr <= ~mapped;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign TEST_MODE           = test_mode;
    assign OSC_FAIL_DISABLE    = test_reg[`OSC_FAIL_DISABLE_BIT];
    assign CLOCK_RUN           = mode_reg[`CLOCK_START_BIT];
    // decoded crystal code, kept as the package enum for readability
    assign xtal_code           = xtal_type'(mode_reg[`XTAL_SEL_HI:`XTAL_SEL_LO]);
    assign XTAL_SELECT         = xtal_code;
    assign BATTERY_BACKED      = (supply_mode == MODE_BATTERY_BACKED);
    // power loss input armed by the top enable
    assign POWER_LOSS_INPUT_EN = intr_enable_1[`POWER_FAIL_EN_BIT];
    assign INTR_ENABLE         = intr_enable_1;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_test_entry;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_flag) |=> (test_mode == $past(wbyte[`TEST_ENTRY_BIT]));
    endproperty
    a_test_entry: assert property (p_test_entry)
        else $error("test mode does not follow flag bit 7");

    property p_test_clear;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_test && test_mode && wbyte == 8'h00) |=> !OSC_FAIL_DISABLE;
    endproperty
    a_test_clear: assert property (p_test_clear)
        else $error("zero write did not clear test conditions");

    property p_xtal;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_mode) |=> (XTAL_SELECT == $past(wbyte[7:6]));
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal select not stored");

    property p_start;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_mode && osc_fail) |=> !CLOCK_RUN;
    endproperty
    a_start: assert property (p_start)
        else $error("clock started with oscillator stopped");

    property p_osc_read;
        @(posedge CLK) disable iff (!NRST)
        (PSEL && !PENABLE && hit_flag) |=> (PRDATA[6] == $past(osc_fail));
    endproperty
    a_osc_read: assert property (p_osc_read)
        else $error("flag bit 6 does not show oscillator state");

    property p_single;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_flag && wbyte[6]) |=> !BATTERY_BACKED;
    endproperty
    a_single: assert property (p_single)
        else $error("one write did not select single supply");

    property p_batt_gate;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_flag && !wbyte[6] && osc_fail) |=> $stable(BATTERY_BACKED);
    endproperty
    a_batt_gate: assert property (p_batt_gate)
        else $error("battery mode changed while oscillator failed");

    property p_power_loss_input;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_ie1) |=> (POWER_LOSS_INPUT_EN == $past(wbyte[7]));
    endproperty
    a_power_loss_input: assert property (p_power_loss_input)
        else $error("power loss input enable not bit 7");

    property p_ready;
        @(posedge CLK) disable iff (!NRST)
        (PSEL && !PENABLE) |=> (PREADY && (PSLVERR == !$past(mapped)));
    endproperty
    a_ready: assert property (p_ready)
        else $error("access answer or error flag wrong");

    property p_unmapped_zero;
        @(posedge CLK) disable iff (!NRST)
        (PSEL && !PENABLE && !mapped) |=> (PRDATA == 32'h0000_0000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned data");

    property p_test_locked;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_test && !test_mode) |=> $stable(test_reg);
    endproperty
    a_test_locked: assert property (p_test_locked)
        else $error("test register written outside test mode");

    property p_start_ok;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_mode && wbyte[`CLOCK_START_BIT] && !osc_fail) |=> CLOCK_RUN;
    endproperty
    a_start_ok: assert property (p_start_ok)
        else $error("clock start refused with oscillator running");

    // a failing oscillator must stop the clock by the next edge, written or not
    property p_run_drop;
        @(posedge CLK) disable iff (!NRST)
        osc_fail |=> !CLOCK_RUN;
    endproperty
    a_run_drop: assert property (p_run_drop)
        else $error("clock kept running with oscillator failed");

    property p_test_read;
        @(posedge CLK) disable iff (!NRST)
        (PSEL && !PENABLE && hit_flag) |=> (PRDATA[7] == $past(test_mode));
    endproperty
    a_test_read: assert property (p_test_read)
        else $error("flag bit 7 does not show test mode");

    property p_status_read;
        @(posedge CLK) disable iff (!NRST)
        (PSEL && !PENABLE && hit_stat) |=>
            (PRDATA[1:0] == {$past(BATTERY_BACKED), $past(osc_fail)});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show supply and oscillator");

    property p_batt_enter;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_flag && !wbyte[`OSC_FAIL_BIT] && !osc_fail) |=> BATTERY_BACKED;
    endproperty
    a_batt_enter: assert property (p_batt_enter)
        else $error("battery mode not entered with oscillator good");

    property p_ie_store;
        @(posedge CLK) disable iff (!NRST)
        (wr && hit_ie1) |=> (INTR_ENABLE == $past(wbyte));
    endproperty
    a_ie_store: assert property (p_ie_store)
        else $error("interrupt enables not stored");
endmodule

// ---- rtc_host.sv ----
// apb host model for the rtc start-up block
// assumes a rising-edge apb slave; the bench calls xfer and reads rdata
`timescale 1ns/1ps
module rtc_host (
    input  wire logic        clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    logic [31:0] rdata = 32'h0;
    logic        rerr  = 1'b0;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    // ------------------------------------------------------------------
    // one transfer
    // ------------------------------------------------------------------
    // whole single transfer
    // no wait-state count is assumed; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ---- rtc_startup_test.sv ----
// self-checking bench of the rtc start-up block
// assumes the host model owns the apb pins and the bench plays the oscillator
`timescale 1ns/1ps
`include "rtc_startup_map.svh"
module rtc_startup_test;
    import rtc_startup_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        osc = 1'b0;
    logic        psel, pen, pwr, pready, perr, tm, ofd, run, bb, ple;
    logic [7:0]  paddr, ie;
    logic [31:0] pwd, prd;
    logic [1:0]  xs;
    int          errors = 0;
    int          n_checks = 0;
    int          i;
    // rows: address, write byte, read-back mask
    logic [23:0] rows [6] = '{24'h04_08_C8, 24'h04_48_C8, 24'h04_88_C8,
                              24'h04_C8_C8, 24'h10_80_FF, 24'h10_55_FF};
    rtc_startup dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr),
        .OSC_RUNNING(osc), .TEST_MODE(tm), .OSC_FAIL_DISABLE(ofd), .CLOCK_RUN(run),
        .XTAL_SELECT(xs), .BATTERY_BACKED(bb), .POWER_LOSS_INPUT_EN(ple),
        .INTR_ENABLE(ie));
    rtc_host host (.clk(clk), .prdata(prd), .pready(pready), .pslverr(perr), .psel(psel),
        .penable(pen), .pwrite(pwr), .paddr(paddr), .pwdata(pwd));
    initial begin
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d);
        #1;
    endtask
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog: the run needs about 115 cycles, the limit is 2500
    initial begin
        #100us;
        errors++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(32'({tm, ofd, run, xs, bb, ple, ie}), 32'h0);
        wr(`PERIODIC_FLAG_ADDR, 8'h80);
        chk(32'(tm), 32'h1);
        host.xfer(1'b0, `PERIODIC_FLAG_ADDR, 8'h00);
        chk(host.rdata, 32'hC0);
        wr(`TEST_MODE_ADDR, 8'h01);
        chk(32'(ofd), 32'h1);
        host.xfer(1'b0, `TEST_MODE_ADDR, 8'h00);
        chk(host.rdata, 32'h01);
        wr(`TEST_MODE_ADDR, 8'h00);
        chk(32'(ofd), 32'h0);
        wr(`PERIODIC_FLAG_ADDR, 8'h00);
        chk(32'({tm, bb}), 32'h0);
        wr(`TEST_MODE_ADDR, 8'h01);
        chk(32'(ofd), 32'h0);
        // start loop with the crystal code held, oscillator wakes on try 3
        for (i = 0; i < 6; i++) begin
            wr(`REALTIME_MODE_ADDR, 8'h48);
            host.xfer(1'b0, `PERIODIC_FLAG_ADDR, 8'h00);
            if (host.rdata[6] === 1'b0) break;
            chk(host.rdata, 32'h40);
            chk(32'(run), 32'h0);
            if (i == 2) osc <= 1'b1;
        end
        chk(32'(i), 32'h3);
        for (int r = 0; r < 6; r++) begin
            wr(rows[r][23:16], rows[r][15:8]);
            if (rows[r][23:16] == `REALTIME_MODE_ADDR)
                chk(32'({xs, run}), 32'({rows[r][15:14], 1'b1}));
            else
                chk(32'({ie, ple}), 32'({rows[r][15:8], rows[r][15]}));
            host.xfer(1'b0, rows[r][23:16], 8'h00);
            chk(host.rdata & 32'(rows[r][7:0]), 32'(rows[r][15:8] & rows[r][7:0]));
        end
        wr(`PERIODIC_FLAG_ADDR, 8'h00);
        chk(32'(bb), 32'h1);
        host.xfer(1'b0, `STATUS_ADDR, 8'h00);
        chk(host.rdata, 32'h02);
        wr(`PERIODIC_FLAG_ADDR, 8'h40);
        chk(32'(bb), 32'h0);
        host.xfer(1'b0, 8'h08, 8'h00);
        chk({host.rdata[30:0], host.rerr}, 32'h1);
        osc <= 1'b0;
        host.xfer(1'b0, `PERIODIC_FLAG_ADDR, 8'h00);
        host.xfer(1'b0, `PERIODIC_FLAG_ADDR, 8'h00);
        chk(host.rdata, 32'h40);
        chk(32'(run), 32'h0);
        host.xfer(1'b0, `STATUS_ADDR, 8'h00);
        chk(host.rdata, 32'h01);
        // reset in mid-run: every register output returns to zero
        nrst <= 1'b0;
        #1;
        chk(32'({tm, ofd, run, xs, bb, ple, ie}), 32'h0);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        wr(`INTR_ENABLE_1_ADDR, 8'h80);
        chk(32'({ie, ple}), 32'h101);
        end_sim();
    end
endmodule
